// File: core/amv_ctrl.sv
// Volume ramp, strap decode, sync select and fault control of the stereo amplifier
// Operation
// - Ramp-up rate from bits 7:6, ramp-down rate from bits 3:2 of ramp control.
// - Ramp-up step from bits 5:4, ramp-down step from bits 1:0 of ramp control.
// - Rate codes: every 1, 2 or 4 sample periods, or direct jump.
// - Step codes 4, 2, 1, 0.5 dB; up raises gain, down lowers it.
// - Clock error or supply failure forces emergency ramp-down using emergency register fields.
// - Emergency ramp defaults to one 4 dB step every sample period.
// - Strap level is decoded at start-up into a 3-bit gain/frequency code.
// - Strap code is captured once and held until power is cycled.
// - Upper four codes 26 dBV, lower four 20 dBV; multiples 8, 6, 5, 4.
// - Sync runs at 96 kHz or 88.2 kHz by sample-rate family.
// - Over-temperature pulls fault low, outputs high-Z, retries after its clear time.
// - Overcurrent pulls fault low, outputs high-Z, retries after its clear time.
// - DC offset pulls fault low, outputs high-Z, latched until mute toggles.
// - A stopped audio clock also clears the DC latch; normal operation resumes after.
// - Volume code 0.5 dB each: 0x00 +24, 0x30 0, 0xFE -103, 0xFF mute.
`timescale 1ns/1ps
module amv_ctrl import amv_pkg::*; #(
  parameter int OT_CLEAR_US = 1000,
  parameter int OC_CLEAR_US = 100,
  parameter int CLR_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire amv_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic sample_tick,
  input wire logic [7:0] vol_target_a,
  input wire logic [7:0] vol_target_b,
  output logic [7:0] vol_gain_a,
  output logic [7:0] vol_gain_b,
  input wire logic clock_error,
  input wire logic supply_fail,
  input wire logic [STRAP_W-1:0] gain_freq_strap_input,
  output logic gain_26dbv,
  output logic [3:0] switch_mult,
  input wire logic fs_family_44k1,
  output logic sync_88k2,
  input wire logic over_temperature_event,
  input wire logic over_current_event,
  input wire logic dc_offset_event,
  input wire logic mute_input_line,
  output logic fault_output_line_o,
  output logic fault_output_line_oe,
  output logic speaker_outputs_hiz
);

  localparam int OT_CLEAR_CYC = OT_CLEAR_US * (CLK_HZ / HZ_PER_MHZ);
  localparam int OC_CLEAR_CYC = OC_CLEAR_US * (CLK_HZ / HZ_PER_MHZ);
  localparam logic [CLR_W-1:0] CLR_LAST [2] = '{CLR_W'(OT_CLEAR_CYC - 1),
                                                 CLR_W'(OC_CLEAR_CYC - 1)};

  // Elaboration-time refusal of settings the clear counters cannot serve
  if (OT_CLEAR_CYC < 1 || OC_CLEAR_CYC < 1) begin : g_bad_clear
    $error("clear times must be at least one cycle");
  end
  if (CLR_W < 1 || CLR_W > 30) begin : g_bad_width
    $error("clear counter width out of range");
  end else if (OT_CLEAR_CYC >= 2 ** CLR_W || OC_CLEAR_CYC >= 2 ** CLR_W) begin : g_narrow
    $error("clear counter too narrow");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ramp registers
  logic [7:0] ramp_ctrl_reg, ramp_ctrl_next;
  logic [7:0] emer_ctrl_reg, emer_ctrl_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    ramp_ctrl_next = ramp_ctrl_reg;
    emer_ctrl_next = emer_ctrl_reg;
    if (reg_req.wr && reg_req.addr == RAMP_CTRL_ADDR) begin
      ramp_ctrl_next = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == EMER_CTRL_ADDR) begin
      emer_ctrl_next = reg_req.wdata;
    end
    unique case (reg_req.addr)
      RAMP_CTRL_ADDR: rdata_next = ramp_ctrl_reg;
      EMER_CTRL_ADDR: rdata_next = emer_ctrl_reg;
      default: rdata_next = RDATA_NONE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ramp_ctrl_reg <= RAMP_CTRL_RST;
      emer_ctrl_reg <= EMER_CTRL_RST;
      rdata_reg <= RDATA_NONE;
    end else begin
      ramp_ctrl_reg <= ramp_ctrl_next;
      emer_ctrl_reg <= emer_ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Channel ramps
  logic emerg;
  assign emerg = clock_error || supply_fail;

  amv_ramp_chan u_ramp_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .sample_tick(sample_tick),
    .target(vol_target_a),
    .emerg(emerg),
    .cfg(amv_ramp_cfg_t'(ramp_ctrl_reg)),
    .ecfg(amv_emer_cfg_t'(emer_ctrl_reg)),
    .gain(vol_gain_a)
  );

  amv_ramp_chan u_ramp_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .sample_tick(sample_tick),
    .target(vol_target_b),
    .emerg(emerg),
    .cfg(amv_ramp_cfg_t'(ramp_ctrl_reg)),
    .ecfg(amv_emer_cfg_t'(emer_ctrl_reg)),
    .gain(vol_gain_b)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture; only a full reset (power cycle) re-arms it
  logic strap_done_reg, strap_done_next;
  logic gain_26_reg, gain_26_next;
  logic [3:0] mult_reg, mult_next;
  logic sync_reg, sync_next;

  always_comb begin
    strap_done_next = 1'b1;
    gain_26_next = gain_26_reg;
    mult_next = mult_reg;
    if (!strap_done_reg) begin
      gain_26_next = gain_freq_strap_input[STRAP_GAIN_BIT];
      mult_next = amv_freq_mult(gain_freq_strap_input[1:0]);
    end
    sync_next = fs_family_44k1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      gain_26_reg <= 1'b0;
      mult_reg <= 4'h4;
      sync_reg <= 1'b0;
    end else begin
      strap_done_reg <= strap_done_next;
      gain_26_reg <= gain_26_next;
      mult_reg <= mult_next;
      sync_reg <= sync_next;
    end
  end

  assign gain_26dbv = gain_26_reg;
  assign switch_mult = mult_reg;
  assign sync_88k2 = sync_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Self-clearing faults: index 0 over-temperature, index 1 overcurrent
  amv_flt_state_t flt_state_reg [2];
  amv_flt_state_t flt_state_next [2];
  logic [CLR_W-1:0] flt_cnt_reg [2];
  logic [CLR_W-1:0] flt_cnt_next [2];
  logic [1:0] flt_ev;
  logic [1:0] flt_on;

  assign flt_ev = {over_current_event, over_temperature_event};

  for (genvar k = 0; k < 2; k++) begin : g_flt
    always_comb begin
      flt_state_next[k] = flt_state_reg[k];
      flt_cnt_next[k] = flt_cnt_reg[k];
      unique case (flt_state_reg[k])
        FLT_OK: if (flt_ev[k]) flt_state_next[k] = FLT_HOLD;
        FLT_HOLD: begin
          if (!flt_ev[k]) begin
            flt_state_next[k] = FLT_CLEAR;
            flt_cnt_next[k] = '0;
          end
        end
        FLT_CLEAR: begin
          // A new event restarts the wait rather than letting the retry through
          if (flt_ev[k]) begin
            flt_state_next[k] = FLT_HOLD;
          end else if (flt_cnt_reg[k] == CLR_LAST[k]) begin
            flt_state_next[k] = FLT_OK;
          end else begin
            flt_cnt_next[k] = flt_cnt_reg[k] + 1'b1;
          end
        end
      endcase
    end

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        flt_state_reg[k] <= FLT_OK;
        flt_cnt_reg[k] <= '0;
      end else begin
        flt_state_reg[k] <= flt_state_next[k];
        flt_cnt_reg[k] <= flt_cnt_next[k];
      end
    end

    assign flt_on[k] = (flt_state_reg[k] != FLT_OK);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Latched DC fault
  logic dc_latch_reg, dc_latch_next;
  logic mute_prev_reg, mute_prev_next;
  logic mute_toggle;

  always_comb begin
    mute_toggle = (mute_input_line != mute_prev_reg);
    mute_prev_next = mute_input_line;
    // A fresh offset wins over a clear in the same cycle
    if (dc_offset_event) begin
      dc_latch_next = 1'b1;
    end else if (mute_toggle || clock_error) begin
      dc_latch_next = 1'b0;
    end else begin
      dc_latch_next = dc_latch_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dc_latch_reg <= 1'b0;
      mute_prev_reg <= 1'b0;
    end else begin
      dc_latch_reg <= dc_latch_next;
      mute_prev_reg <= mute_prev_next;
    end
  end

  // Open-drain fault line: only ever pulls low
  assign fault_output_line_o = 1'b0;
  assign fault_output_line_oe = (|flt_on) || dc_latch_reg;
  assign speaker_outputs_hiz = (|flt_on) || dc_latch_reg;

  //////////////////////////////////////////////////////////////////////////////
  ramp_ctrl_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_req.wr && reg_req.addr == RAMP_CTRL_ADDR) |=> (ramp_ctrl_reg == $past(reg_req.wdata)))
    else $error("ramp control write lost");

  emer_default_a: assert property (@(posedge clk_sys)
    rst |=> (emer_ctrl_reg == EMER_CTRL_RST && ramp_ctrl_reg == RAMP_CTRL_RST))
    else $error("ramp registers not at reset value");

  strap_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    strap_done_reg |=> ($stable(gain_26_reg) && $stable(mult_reg)))
    else $error("strap decode changed after start-up");

  strap_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!strap_done_reg && gain_freq_strap_input == 3'h7) |=> (gain_26dbv && switch_mult == 4'h8))
    else $error("top strap code decoded wrongly");

  sync_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    fs_family_44k1 |=> sync_88k2)
    else $error("sync rate not following sample family");

  ot_fault_a: assert property (@(posedge clk_sys) disable iff (rst)
    (over_temperature_event ##1 !over_temperature_event) |=>
    (fault_output_line_oe && speaker_outputs_hiz))
    else $error("over-temperature released without clear time");

  oc_fault_a: assert property (@(posedge clk_sys) disable iff (rst)
    over_current_event |=> (fault_output_line_oe && speaker_outputs_hiz))
    else $error("overcurrent did not raise fault");

  dc_latched_a: assert property (@(posedge clk_sys) disable iff (rst)
    (dc_latch_reg && !mute_toggle && !clock_error) |=> (dc_latch_reg && fault_output_line_oe))
    else $error("dc fault dropped without mute toggle");

  clk_err_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clock_error && !dc_offset_event) |=> !dc_latch_reg)
    else $error("clock error did not clear dc fault");

  ot_retry_c: cover property (@(posedge clk_sys) disable iff (rst)
    flt_state_reg[0] == FLT_CLEAR ##1 flt_state_reg[0] == FLT_OK);
  dc_clear_c: cover property (@(posedge clk_sys) disable iff (rst)
    dc_latch_reg ##1 mute_toggle ##1 !dc_latch_reg);
  strap_c: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(strap_done_reg) && gain_freq_strap_input[2]);

endmodule // amv_ctrl

// File: core/amv_pkg.sv
// Shared constants, types and decode helpers for the amplifier volume ramp and fault control
package amv_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;

  // Register map and reset values
  localparam logic [7:0] RAMP_CTRL_ADDR = 8'h3F;
  localparam logic [7:0] EMER_CTRL_ADDR = 8'h40;
  localparam logic [7:0] RAMP_CTRL_RST = 8'h22;
  localparam logic [7:0] EMER_CTRL_RST = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // Volume codes, 0.5 dB per code, larger code is lower gain
  localparam logic [7:0] VOL_DEFAULT = 8'h30;
  localparam logic [7:0] VOL_MUTE = 8'hFF;

  localparam logic [1:0] RATE_DIRECT = 2'h3;
  localparam int STRAP_W = 3;
  localparam int STRAP_GAIN_BIT = 2;

  // Field layout matches the ramp control byte, bit 7 first
  typedef struct packed {
    logic [1:0] up_rate;
    logic [1:0] up_step;
    logic [1:0] dn_rate;
    logic [1:0] dn_step;
  } amv_ramp_cfg_t;

  typedef struct packed {
    logic [1:0] rate;
    logic [1:0] step;
    logic [3:0] unused;
  } amv_emer_cfg_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } amv_reg_req_t;

  typedef enum logic [1:0] {FLT_OK, FLT_HOLD, FLT_CLEAR} amv_flt_state_t;

  // Step size in half-dB codes: 4.0, 2.0, 1.0, 0.5 dB
  function automatic logic [7:0] amv_step_size(input logic [1:0] code);
    unique case (code)
      2'h0: amv_step_size = 8'h08;
      2'h1: amv_step_size = 8'h04;
      2'h2: amv_step_size = 8'h02;
      2'h3: amv_step_size = 8'h01;
    endcase
  endfunction

  // Last sample-tick count before a step: every 1, 2 or 4 periods
  function automatic logic [1:0] amv_rate_last(input logic [1:0] code);
    unique case (code)
      2'h0: amv_rate_last = 2'h0;
      2'h1: amv_rate_last = 2'h1;
      2'h2: amv_rate_last = 2'h3;
      2'h3: amv_rate_last = 2'h0;
    endcase
  endfunction

  // Switching multiple of the sync rate within a gain group
  function automatic logic [3:0] amv_freq_mult(input logic [1:0] code);
    unique case (code)
      2'h3: amv_freq_mult = 4'h8;
      2'h2: amv_freq_mult = 4'h6;
      2'h1: amv_freq_mult = 4'h5;
      2'h0: amv_freq_mult = 4'h4;
    endcase
  endfunction

endpackage

// File: core/amv_ramp_chan.sv
// One channel of soft volume ramping toward a target code
`timescale 1ns/1ps
module amv_ramp_chan import amv_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sample_tick,
  input wire logic [7:0] target,
  input wire logic emerg,
  input wire amv_ramp_cfg_t cfg,
  input wire amv_emer_cfg_t ecfg,
  output logic [7:0] gain
);

  logic [7:0] gain_reg, gain_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [7:0] tgt, size, delta;
  logic [1:0] rate, stp;
  logic fire;

  always_comb begin
    tgt = emerg ? VOL_MUTE : target;
    if (emerg) begin
      rate = ecfg.rate;
      stp = ecfg.step;
    end else if (target < gain_reg) begin
      rate = cfg.up_rate;
      stp = cfg.up_step;
    end else begin
      rate = cfg.dn_rate;
      stp = cfg.dn_step;
    end
    size = amv_step_size(stp);
    delta = (tgt > gain_reg) ? tgt - gain_reg : gain_reg - tgt;
    fire = sample_tick && (cnt_reg >= amv_rate_last(rate));
    cnt_next = cnt_reg;
    gain_next = gain_reg;
    if (sample_tick) begin
      cnt_next = fire ? 2'h0 : cnt_reg + 2'h1;
    end
    if (rate == RATE_DIRECT) begin
      gain_next = tgt;
      cnt_next = 2'h0;
    end else if (fire) begin
      // Last step is clamped so the gain lands on the target exactly
      if (delta <= size) begin
        gain_next = tgt;
      end else if (tgt > gain_reg) begin
        gain_next = gain_reg + size;
      end else begin
        gain_next = gain_reg - size;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gain_reg <= VOL_DEFAULT;
      cnt_reg <= 2'h0;
    end else begin
      gain_reg <= gain_next;
      cnt_reg <= cnt_next;
    end
  end

  assign gain = gain_reg;

  //////////////////////////////////////////////////////////////////////////////
  ramp_no_overshoot_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!emerg && $stable(target) && gain_reg <= target) |=> (gain_reg <= $past(target)))
    else $error("ramp passed its target");

  ramp_direct_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!emerg && rate == RATE_DIRECT) |=> (gain_reg == $past(target)))
    else $error("direct change did not land on target");

  ramp_slow_rate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!emerg && rate == 2'h2 && cnt_reg == 2'h0 && sample_tick) |=> $stable(gain_reg))
    else $error("ramp stepped before fourth sample");

  emer_step_a: assert property (@(posedge clk_sys) disable iff (rst)
    (emerg && ecfg.rate == 2'h0 && ecfg.step == 2'h0 && sample_tick && gain_reg < 8'hF7)
    |=> (gain_reg == $past(gain_reg) + 8'h08))
    else $error("emergency step is not 4 dB per sample");

  ramp_emer_c: cover property (@(posedge clk_sys) disable iff (rst)
    emerg ##1 gain_reg == VOL_MUTE);

endmodule // amv_ramp_chan

// File: test/amv_host_model.sv
// Audio host stand-in that issues one sample tick per sample period
`timescale 1ns/1ps
module amv_host_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] gap,
  output logic sample_tick
);
  logic [7:0] cnt_reg;
  // Silent while stopped, like a halted frame clock, so no stray tick skews a ramp
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      cnt_reg <= 8'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= (cnt_reg >= gap);
      cnt_reg <= (cnt_reg >= gap) ? 8'h00 : cnt_reg + 8'h01;
    end
  end
endmodule // amv_host_model

// File: test/amv_ctrl_tb.sv
// Self-checking bench for the volume ramp, strap decode and fault control
`timescale 1ns/1ps
module amv_ctrl_tb;
  import amv_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  amv_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata, vol_gain_a, vol_gain_b, vol_target_a = 8'h30, vol_target_b = 8'h30;
  logic sample_tick, gain_26dbv, sync_88k2, fault_output_line_o, fault_output_line_oe;
  logic speaker_outputs_hiz, run = 1'b0;
  logic clock_error = 1'b0, supply_fail = 1'b0, fs_family_44k1 = 1'b0, mute_input_line = 1'b0;
  logic over_temperature_event = 1'b0, over_current_event = 1'b0, dc_offset_event = 1'b0;
  logic [2:0] gain_freq_strap_input = 3'h0;
  logic [3:0] switch_mult;
  logic [7:0] gap = 8'h03;
  integer seed = 32'hFE6BBF4E;
  logic [31:0] d;
  int errors = 0;
  int checks_done = 0;
  int i;
  always #50 clk_sys = ~clk_sys;
  amv_ctrl #(.OT_CLEAR_US(1), .OC_CLEAR_US(2)) amv_ctrl_i (.clk_sys(clk_sys), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
    .vol_target_a(vol_target_a), .vol_target_b(vol_target_b), .vol_gain_a(vol_gain_a),
    .vol_gain_b(vol_gain_b), .clock_error(clock_error), .supply_fail(supply_fail),
    .gain_freq_strap_input(gain_freq_strap_input), .gain_26dbv(gain_26dbv),
    .switch_mult(switch_mult), .fs_family_44k1(fs_family_44k1), .sync_88k2(sync_88k2),
    .over_temperature_event(over_temperature_event), .over_current_event(over_current_event),
    .dc_offset_event(dc_offset_event), .mute_input_line(mute_input_line),
    .fault_output_line_o(fault_output_line_o), .fault_output_line_oe(fault_output_line_oe),
    .speaker_outputs_hiz(speaker_outputs_hiz));
  amv_host_model amv_host_model_i (.clk_sys(clk_sys), .rst(rst), .run(run), .gap(gap),
    .sample_tick(sample_tick));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Strap is held through reset and sampled at the first edge with reset low
  task automatic do_reset(input logic [2:0] s, input logic fam);
    @(posedge clk_sys);
    rst <= 1'b1;
    run <= 1'b0;
    gain_freq_strap_input <= s;
    fs_family_44k1 <= fam;
    // Targets back at the reset gain, so a direct rate cannot jump before a ramp starts
    vol_target_a <= 8'h30;
    vol_target_b <= 8'h30;
    cyc(4);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{1'b1, a, v};
    @(posedge clk_sys);
    reg_req <= '{1'b0, a, 8'h00};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{1'b0, a, 8'h00};
    cyc(2);
    @(negedge clk_sys);
    chk(reg_rdata, v);
  endtask
  task automatic wait_tick;
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_sys);
      if (sample_tick === 1'b1) break;
    end
    if (n == 40) begin
      errors++;
      report_and_stop();
    end
  endtask
  // Expected gain after one tick; c holds up rate, up step, down rate, down step
  function automatic logic [7:0] mv(input logic [7:0] g, input logic [7:0] t,
      input logic [7:0] c, inout int k);
    logic [1:0] r;
    int dd;
    r = (t < g) ? c[7:6] : c[3:2];
    dd = 8 >> ((t < g) ? c[5:4] : c[1:0]);
    if (t == g) return g;
    if (r == 2'h3) return t;
    k++;
    if (k < (1 << r)) return g;
    k = 0;
    if (t < g) return (g - t > dd) ? g - 8'(dd) : t;
    return (t - g > dd) ? g + 8'(dd) : t;
  endfunction
  // src 0 ramps to the targets, 1 and 2 hold a clock error or supply failure
  task automatic ramp(input logic [7:0] ta, input logic [7:0] tb, input logic [7:0] c,
      input int ticks, input int src);
    logic [7:0] ga, gb;
    int ka, kb;
    ga = 8'h30;
    gb = 8'h30;
    ka = 0;
    kb = 0;
    @(posedge clk_sys);
    if (src == 0) begin
      vol_target_a <= ta;
      vol_target_b <= tb;
    end
    clock_error <= (src == 1);
    supply_fail <= (src == 2);
    gap <= 8'(3 + {$random(seed)} % 6);
    run <= 1'b1;
    repeat (ticks) begin
      wait_tick();
      ga = mv(ga, ta, c, ka);
      gb = mv(gb, tb, c, kb);
      cyc(2);
      @(negedge clk_sys);
      chk(vol_gain_a, ga);
      chk(vol_gain_b, gb);
    end
    @(posedge clk_sys);
    run <= 1'b0;
    clock_error <= 1'b0;
    supply_fail <= 1'b0;
  endtask
  task automatic fault_nl(input int oc, input int n10);
    int n;
    @(posedge clk_sys);
    over_temperature_event <= (oc == 0);
    over_current_event <= (oc == 1);
    cyc(3);
    @(negedge clk_sys);
    chk({fault_output_line_oe, speaker_outputs_hiz, fault_output_line_o}, 3'h6);
    @(posedge clk_sys);
    over_temperature_event <= 1'b0;
    over_current_event <= 1'b0;
    for (n = 0; n < 100; n++) begin
      @(negedge clk_sys);
      if (fault_output_line_oe !== 1'b1) break;
    end
    chk(n >= n10 && n <= n10 + 4, 1);
    chk(speaker_outputs_hiz, 1'b0);
    if (n == 100) report_and_stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset(3'h0, 1'b0);
    @(negedge clk_sys);
    chk(vol_gain_a, 8'h30);
    rd(RAMP_CTRL_ADDR, 8'h22);
    rd(EMER_CTRL_ADDR, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(i[0] ? EMER_CTRL_ADDR : RAMP_CTRL_ADDR, d[7:0]);
      wr(8'h41, ~d[7:0]);
      rd(i[0] ? EMER_CTRL_ADDR : RAMP_CTRL_ADDR, d[7:0]);
      rd(8'h41, 8'h00);
    end
    $display("Register test done");
    for (i = 0; i < 8; i++) begin
      do_reset(i[2:0], i[0]);
      gain_freq_strap_input <= ~i[2:0];
      cyc(3);
      @(negedge clk_sys);
      chk(gain_26dbv, i[2]);
      chk(switch_mult, (i[1:0] == 3) ? 8 : (i[1:0] == 2) ? 6 : (i[1:0] == 1) ? 5 : 4);
      chk(sync_88k2, i[0]);
    end
    $display("Strap test done");
    do_reset(3'h0, 1'b0);
    wr(RAMP_CTRL_ADDR, 8'h00);
    ramp(8'h00, 8'h35, 8'h00, 8, 0);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      do_reset(3'h0, 1'b0);
      wr(RAMP_CTRL_ADDR, d[7:0]);
      ramp(d[15:8], (i == 0) ? 8'hFF : d[23:16], d[7:0], 10, 0);
    end
    $display("Ramp test done");
    do_reset(3'h0, 1'b0);
    ramp(8'hFF, 8'hFF, 8'h00, 28, 1);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      do_reset(3'h0, 1'b0);
      wr(EMER_CTRL_ADDR, d[7:0]);
      ramp(8'hFF, 8'hFF, {4'h0, d[7:4]}, 12, 1 + i[0]);
    end
    $display("Emergency test done");
    fault_nl(0, 10);
    fault_nl(1, 20);
    @(posedge clk_sys);
    dc_offset_event <= 1'b1;
    @(posedge clk_sys);
    dc_offset_event <= 1'b0;
    cyc(12);
    @(negedge clk_sys);
    chk({fault_output_line_oe, speaker_outputs_hiz, fault_output_line_o}, 3'h6);
    @(posedge clk_sys);
    mute_input_line <= ~mute_input_line;
    cyc(2);
    @(negedge clk_sys);
    chk({fault_output_line_oe, speaker_outputs_hiz}, 2'h0);
    @(posedge clk_sys);
    dc_offset_event <= 1'b1;
    @(posedge clk_sys);
    dc_offset_event <= 1'b0;
    cyc(4);
    clock_error <= 1'b1;
    @(posedge clk_sys);
    clock_error <= 1'b0;
    cyc(2);
    @(negedge clk_sys);
    chk({fault_output_line_oe, speaker_outputs_hiz}, 2'h0);
    $display("Fault test done");
    report_and_stop();
  end
endmodule // amv_ctrl_tb
